// ===== inc/fpepc_pkg.sv
package fpepc_pkg;
  // special function register addresses
  localparam logic [7:0] ADDR_COMMAND_STATUS = 8'h00_E4;
  localparam logic [7:0] ADDR_DATA           = 8'h00_E5;
  localparam logic [7:0] ADDR_ADDR_LOW       = 8'h00_E6;
  localparam logic [7:0] ADDR_ADDR_HIGH      = 8'h00_E7;
  // command codes
  localparam logic [7:0] CMD_LOAD            = 8'h00_00;
  localparam logic [7:0] CMD_ERASE_PROGRAM   = 8'h00_68;
  // status field positions
  localparam int         BIT_OP_INTERRUPTED  = 0;
  localparam int         BIT_SECURITY        = 1;
  localparam int         BIT_HV_ERROR        = 2;
  localparam int         BIT_HV_ABORT        = 3;
  localparam logic [3:0] STATUS_RESET        = 4'h0_0;
  localparam logic [7:0] ADDR_RESET          = 8'h00_00;
  // page register geometry
  localparam int         PAGE_BYTES          = 16;
  localparam int         PAGE_IDX_W          = 4;
  // cycle timing
  localparam int         CLOCK_MHZ           = 100;
  localparam int         CYCLE_TIME_US       = 4000;
  localparam int         CYCLE_CLOCKS        = CYCLE_TIME_US * CLOCK_MHZ;
  // sequencer states
  typedef enum logic [1:0] {
    FPEPC_IDLE   = 2'b00,
    FPEPC_ERASE  = 2'b01,
    FPEPC_WRITE  = 2'b10,
    FPEPC_FINISH = 2'b11
  } fpepc_state_type;
endpackage

// ===== hdl/fpepc_page_mem.sv
`timescale 1ns/1ps
// sixteen-byte page register with one update flag per byte
module fpepc_page_mem #(
  parameter int DEPTH = 16,
  parameter int IDX_W = 4
) (
  // clock and reset
  input  wire logic             clock_in,
  input  wire logic             sys_rst_in,
  // load side
  input  wire logic             clear_in,
  input  wire logic             write_in,
  input  wire logic [IDX_W-1:0] write_idx_in,
  input  wire logic [7:0]       write_data_in,
  // read side
  input  wire logic [IDX_W-1:0] read_idx_in,
  output logic      [7:0]       read_data_out,
  output logic                  read_flag_out
);
  logic [7:0]       bytes [DEPTH];
  logic [DEPTH-1:0] flags;

  // storage; a clear empties bytes and flags
  always_ff @(posedge clock_in) begin
    if (sys_rst_in || clear_in) begin
      flags <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        bytes[i] <= 8'h00_00;
      end
    end else if (write_in) begin
      bytes[write_idx_in] <= write_data_in;
      flags[write_idx_in] <= 1'b1;
    end
  end

  // registered read port
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      read_data_out <= 8'h00_00;
      read_flag_out <= 1'b0;
    end else begin
      read_data_out <= bytes[read_idx_in];
      read_flag_out <= flags[read_idx_in];
    end
  end
endmodule

// ===== hdl/fpepc_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - page register holds sixteen bytes, each with an update flag
// - load command 00h clears all page bytes and update flags
// - data write stores byte at low address nibble, sets its flag
// - each data write bumps low nibble with wrap, upper nibble kept
// - page number is high address with low address bits 7:4
// - command 68h erases and programs only flagged bytes of page
// - erase-program holds the processor idle until finish or abort
// - interrupt during a cycle aborts it and sets interrupted flag
// - erase-program cycle lasts 4 ms whatever bytes are flagged
// - status reads back, writes are commands, any command written while idle clears status
// - status bit 0 marks cycle aborted by interrupt
// - status bit 1 marks operation aimed at a secured page
// - status bit 2 marks high voltage generator fault
// - status bit 3 marks interrupt, brown-out, or detector disabled at start
// - status bits 7:4 always read zero
module fpepc_ctrl #(
  parameter int CYCLE_CLOCKS = fpepc_pkg::CYCLE_CLOCKS,
  parameter int PAGE_W       = 12
) (
  // clock and reset
  input  wire logic              clock_in,
  input  wire logic              sys_rst_in,
  // special function register port
  input  wire logic [7:0]        sfr_addr_in,
  input  wire logic              sfr_write_in,
  input  wire logic [7:0]        sfr_wdata_in,
  output logic      [7:0]        sfr_rdata_out,
  // processor hold and events
  input  wire logic              irq_pending_in,
  output logic                   cpu_hold_out,
  // flash array side
  input  wire logic              page_secured_in,
  input  wire logic              hv_fault_in,
  input  wire logic              brownout_in,
  input  wire logic              brownout_enabled_in,
  output logic                   flash_erase_out,
  output logic                   flash_write_out,
  output logic      [PAGE_W-1:0] flash_page_out,
  output logic      [3:0]        flash_byte_out,
  output logic      [7:0]        flash_data_out
);
  localparam int CNT_W = $clog2(CYCLE_CLOCKS + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CYCLE_CLOCKS - 1);

  // pin-level inputs pass two flip-flops
  logic [1:0] sync_irq;
  logic [1:0] sync_hv;
  logic [1:0] sync_bo;
  logic [1:0] sync_boen;
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      sync_irq  <= 2'b00;
      sync_hv   <= 2'b00;
      sync_bo   <= 2'b00;
      sync_boen <= 2'b00;
    end else begin
      sync_irq  <= {sync_irq[0], irq_pending_in};
      sync_hv   <= {sync_hv[0], hv_fault_in};
      sync_bo   <= {sync_bo[0], brownout_in};
      sync_boen <= {sync_boen[0], brownout_enabled_in};
    end
  end
  wire irq_s  = sync_irq[1];
  wire hv_s   = sync_hv[1];
  wire bo_s   = sync_bo[1];
  wire boen_s = sync_boen[1];

  // register state
  fpepc_pkg::fpepc_state_type state;
  fpepc_pkg::fpepc_state_type next_state;
  logic [7:0]       addr_low;
  logic [7:0]       addr_high;
  logic [3:0]       status;
  logic [CNT_W-1:0] cycle_cnt;
  logic [4:0]       scan_idx;
  logic             scan_valid;
  logic [3:0]       scan_byte_d;

  // write decode
  wire wr_cmd  = sfr_write_in && (sfr_addr_in == fpepc_pkg::ADDR_COMMAND_STATUS);
  wire wr_data = sfr_write_in && (sfr_addr_in == fpepc_pkg::ADDR_DATA);
  wire wr_low  = sfr_write_in && (sfr_addr_in == fpepc_pkg::ADDR_ADDR_LOW);
  wire wr_high = sfr_write_in && (sfr_addr_in == fpepc_pkg::ADDR_ADDR_HIGH);
  wire busy    = (state != fpepc_pkg::FPEPC_IDLE);
  wire cmd_load  = wr_cmd && !busy && (sfr_wdata_in == fpepc_pkg::CMD_LOAD);
  wire cmd_ep    = wr_cmd && !busy && (sfr_wdata_in == fpepc_pkg::CMD_ERASE_PROGRAM);
  wire data_load = wr_data && !busy;

  // abort sources while a cycle runs
  wire abort_irq = busy && irq_s;
  wire abort_hv  = busy && hv_s;
  wire abort_bo  = busy && bo_s;
  wire abort_any = abort_irq || abort_hv || abort_bo;
  wire sec_block = cmd_ep && page_secured_in;
  wire bo_off    = cmd_ep && !boen_s;
  wire cycle_end = busy && (cycle_cnt == CNT_LAST);
  wire [4:0] scan_next = scan_idx + 5'd1;

  // page register instance
  logic [7:0] mem_rdata;
  logic       mem_rflag;
  fpepc_page_mem #(
    .DEPTH (fpepc_pkg::PAGE_BYTES),
    .IDX_W (fpepc_pkg::PAGE_IDX_W)
  ) u_page (
    .clock_in      (clock_in),
    .sys_rst_in    (sys_rst_in),
    .clear_in      (cmd_load),
    .write_in      (data_load),
    .write_idx_in  (addr_low[3:0]),
    .write_data_in (sfr_wdata_in),
    .read_idx_in   (scan_idx[3:0]),
    .read_data_out (mem_rdata),
    .read_flag_out (mem_rflag)
  );

  // next state
  always_comb begin
    next_state = state;
    case (state)
      fpepc_pkg::FPEPC_IDLE: begin
        if (cmd_ep && !sec_block && !bo_off) begin
          next_state = fpepc_pkg::FPEPC_ERASE;
        end
      end
      fpepc_pkg::FPEPC_ERASE: begin
        next_state = fpepc_pkg::FPEPC_WRITE;
      end
      fpepc_pkg::FPEPC_WRITE: begin
        if (scan_idx == 5'(fpepc_pkg::PAGE_BYTES) && !scan_valid) begin
          next_state = fpepc_pkg::FPEPC_FINISH;
        end
      end
      fpepc_pkg::FPEPC_FINISH: begin
        if (cycle_end) begin
          next_state = fpepc_pkg::FPEPC_IDLE;
        end
      end
      default: next_state = fpepc_pkg::FPEPC_IDLE;
    endcase
    if (abort_any) begin
      next_state = fpepc_pkg::FPEPC_IDLE;
    end
  end

  // sequencer, cycle timer and byte scan
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state      <= fpepc_pkg::FPEPC_IDLE;
      cycle_cnt  <= '0;
      scan_idx   <= 5'd0;
      scan_valid <= 1'b0;
    end else begin
      state      <= next_state;
      cycle_cnt  <= busy ? cycle_cnt + CNT_W'(1) : '0;
      scan_valid <= (state == fpepc_pkg::FPEPC_WRITE) && !scan_idx[4];
      if (state == fpepc_pkg::FPEPC_WRITE && !scan_idx[4]) begin
        scan_idx <= scan_next;
      end else if (state == fpepc_pkg::FPEPC_IDLE) begin
        scan_idx <= 5'd0;
      end
    end
  end

  // address registers with auto-increment
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      addr_low  <= fpepc_pkg::ADDR_RESET;
      addr_high <= fpepc_pkg::ADDR_RESET;
    end else begin
      if (wr_low && !busy) begin
        addr_low <= sfr_wdata_in;
      end else if (data_load) begin
        addr_low <= {addr_low[7:4], addr_low[3:0] + 4'd1};
      end
      if (wr_high && !busy) begin
        addr_high <= sfr_wdata_in;
      end
    end
  end

  // status flags: events win over a same-cycle command clear
  logic [3:0] next_status;
  always_comb begin
    next_status = status;
    if (wr_cmd && !busy) begin
      next_status = fpepc_pkg::STATUS_RESET;
    end
    if (abort_irq) begin
      next_status[fpepc_pkg::BIT_OP_INTERRUPTED] = 1'b1;
    end
    if (sec_block) begin
      next_status[fpepc_pkg::BIT_SECURITY] = 1'b1;
    end
    if (abort_hv) begin
      next_status[fpepc_pkg::BIT_HV_ERROR] = 1'b1;
    end
    if (abort_irq || abort_bo || bo_off) begin
      next_status[fpepc_pkg::BIT_HV_ABORT] = 1'b1;
    end
  end
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      status <= fpepc_pkg::STATUS_RESET;
    end else begin
      status <= next_status;
    end
  end

  // register read data and outputs, all from flip-flops
  logic [7:0] next_rdata;
  always_comb begin
    case (sfr_addr_in)
      fpepc_pkg::ADDR_COMMAND_STATUS: next_rdata = {4'h0_0, next_status};
      fpepc_pkg::ADDR_ADDR_LOW:       next_rdata = addr_low;
      fpepc_pkg::ADDR_ADDR_HIGH:      next_rdata = addr_high;
      default:                        next_rdata = 8'h00_00;
    endcase
  end
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      sfr_rdata_out   <= 8'h00_00;
      cpu_hold_out    <= 1'b0;
      flash_erase_out <= 1'b0;
      flash_write_out <= 1'b0;
      flash_page_out  <= '0;
      flash_byte_out  <= 4'h0_0;
      flash_data_out  <= 8'h00_00;
      scan_byte_d     <= 4'h0_0;
    end else begin
      sfr_rdata_out   <= next_rdata;
      cpu_hold_out    <= (next_state != fpepc_pkg::FPEPC_IDLE);
      flash_erase_out <= (next_state == fpepc_pkg::FPEPC_ERASE);
      scan_byte_d     <= scan_idx[3:0];
      flash_write_out <= scan_valid && mem_rflag && !abort_any;
      flash_byte_out  <= scan_byte_d;
      flash_data_out  <= mem_rdata;
      flash_page_out  <= PAGE_W'({addr_high, addr_low[7:4]});
    end
  end

  // checks
  chk_load_clears: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    cmd_load |=> !u_page.flags[0] && (u_page.flags == '0))
    else $error("load did not clear flags");
  chk_data_sets_flag: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    data_load |=> u_page.flags[$past(addr_low[3:0])])
    else $error("data write did not set flag");
  chk_addr_wrap: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    data_load && !wr_low |=> addr_low == {$past(addr_low[7:4]), $past(addr_low[3:0]) + 4'd1})
    else $error("address increment wrong");
  chk_page_form: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    ##1 flash_page_out == PAGE_W'({$past(addr_high), $past(addr_low[7:4])}))
    else $error("page number wrong");
  chk_only_flagged: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    flash_write_out |-> u_page.flags[flash_byte_out])
    else $error("unflagged byte written");
  chk_hold_start: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    cmd_ep && !sec_block && !bo_off && !abort_any |=> cpu_hold_out)
    else $error("hold not raised");
  chk_irq_abort: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    abort_irq |=> !busy && status[fpepc_pkg::BIT_OP_INTERRUPTED]
      && status[fpepc_pkg::BIT_HV_ABORT])
    else $error("interrupt abort missing");
  chk_cycle_len: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    busy && !abort_any && !cycle_end |=> busy)
    else $error("cycle ended early");
  chk_other_cmd: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    wr_cmd && !cmd_load && !cmd_ep && !busy |=> !busy && $stable(u_page.flags))
    else $error("other command had effect");
  chk_upper_zero: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $past(sfr_addr_in) == fpepc_pkg::ADDR_COMMAND_STATUS |-> sfr_rdata_out[7:4] == 4'h0_0)
    else $error("status upper bits not zero");

  // named steps of a cycle start and of a cycle end or abort
  sequence seq_ep_accept;
    cmd_ep && !sec_block && !bo_off;
  endsequence
  sequence seq_erase_pulse;
    flash_erase_out && cpu_hold_out;
  endsequence
  sequence seq_erase_gone;
    !flash_erase_out && cpu_hold_out;
  endsequence
  sequence seq_all_quiet;
    !busy && !cpu_hold_out && !flash_erase_out && !flash_write_out;
  endsequence
  chk_start_steps: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    seq_ep_accept ##1 !abort_any |-> seq_erase_pulse ##1 seq_erase_gone)
    else $error("cycle start steps wrong");
  chk_abort_quiet: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    abort_any |=> seq_all_quiet)
    else $error("outputs active after abort");
  chk_end_release: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    cycle_end |=> seq_all_quiet)
    else $error("cycle end did not release");
  chk_write_data: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    flash_write_out |-> flash_data_out == u_page.bytes[flash_byte_out])
    else $error("programmed data differs from page byte");
  chk_cmd_clears: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    wr_cmd && !busy && !sec_block && !bo_off |=> status == fpepc_pkg::STATUS_RESET)
    else $error("command did not clear status");
  chk_secured_refused: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    sec_block |=> !busy && status[fpepc_pkg::BIT_SECURITY])
    else $error("secured page not refused");
  chk_hv_error: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    abort_hv |=> status[fpepc_pkg::BIT_HV_ERROR])
    else $error("voltage fault not flagged");
  chk_brownout_off: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    bo_off |=> !busy && status[fpepc_pkg::BIT_HV_ABORT])
    else $error("disabled detector not refused");
endmodule

// ===== dv/fpepc_cpu.sv
`timescale 1ns/1ps
// processor core model on the register port
module fpepc_cpu (
  // clock
  input  wire logic       clock_in,
  // register port
  output logic      [7:0] addr_out,
  output logic            wr_out,
  output logic      [7:0] wdata_out,
  input  wire logic [7:0] rdata_in
);
  // idle port at time zero
  initial begin
    addr_out = 8'h00_00;
    wr_out = 1'b0;
    wdata_out = 8'h00_00;
  end
  // one write, strobe for one cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge clock_in);
    wr_out = 1'b0;
    wdata_out = ~d; // released data never shows the last value
  endtask
  // one read, data a cycle after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock_in);
    addr_out = a;
    @(negedge clock_in);
    d = rdata_in;
  endtask
  // fresh load, address, n bytes in one page, each once
  task automatic load(input logic [7:0] hi, lo, d, input int n);
    wr(fpepc_pkg::ADDR_COMMAND_STATUS, fpepc_pkg::CMD_LOAD);
    wr(fpepc_pkg::ADDR_ADDR_HIGH, hi);
    wr(fpepc_pkg::ADDR_ADDR_LOW, lo);
    for (int i = 0; i < n; i++) begin
      wr(fpepc_pkg::ADDR_DATA, d + 8'(i));
    end
  endtask
endmodule

// ===== dv/tb.sv
`timescale 1ns/1ps
// bench for the flash page erase-program controller
module tb;
  localparam int CYC = 64;
  // stimulus and ports
  logic        clock_in;
  logic        sys_rst_in;
  logic [2:0]  cause;
  logic        secured;
  logic        bo_en;
  logic [7:0]  addr;
  logic        wr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        hold;
  logic        erase;
  logic        fwr;
  logic [11:0] page;
  logic [3:0]  fbyte;
  logic [7:0]  fdata;
  // scoreboard
  int          n_fail = 0;
  int          total_checks = 0;
  int          n_erase;
  int          n_wr;
  int          n;
  logic [7:0]  rv;
  logic [11:0] seen_page;
  logic [7:0]  seen_data [16];
  logic [15:0] seen_flag;
  logic [7:0]  abort_exp [3] = '{8'h00_09, 8'h00_04, 8'h00_08};

  fpepc_ctrl #(.CYCLE_CLOCKS(CYC)) u_dut (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .sfr_addr_in(addr), .sfr_write_in(wr), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
    .irq_pending_in(cause[0]), .cpu_hold_out(hold),
    .page_secured_in(secured), .hv_fault_in(cause[1]), .brownout_in(cause[2]),
    .brownout_enabled_in(bo_en), .flash_erase_out(erase), .flash_write_out(fwr),
    .flash_page_out(page), .flash_byte_out(fbyte), .flash_data_out(fdata));
  fpepc_cpu u_cpu (
    .clock_in(clock_in), .addr_out(addr), .wr_out(wr), .wdata_out(wdata), .rdata_in(rdata));

  // 100 MHz clock
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  // capture erase pulses and programmed bytes
  always @(negedge clock_in) begin
    if (erase === 1'b1) begin
      n_erase++;
      seen_page = page;
    end
    if (fwr === 1'b1) begin
      n_wr++;
      seen_data[fbyte] = fdata;
      seen_flag[fbyte] = 1'b1;
    end
  end
  // compare and count
  task automatic chk(input string what, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // erase-program command with cleared capture
  task automatic start();
    n_erase = 0;
    n_wr = 0;
    seen_flag = 16'h0000;
    u_cpu.wr(fpepc_pkg::ADDR_COMMAND_STATUS, fpepc_pkg::CMD_ERASE_PROGRAM);
    @(negedge clock_in);
  endtask
  task automatic status(input logic [7:0] e);
    u_cpu.rd(fpepc_pkg::ADDR_COMMAND_STATUS, rv);
    chk("status", {8'h00, rv}, {8'h00, e});
  endtask
  // bounded wait for the processor hold to drop
  task automatic wait_fall(input int lim);
    n = 1;
    while (hold === 1'b1) begin
      @(negedge clock_in);
      n++;
      if (n > lim) begin
        chk("hold timeout", 16'h0001, 16'h0000);
        give_verdict();
      end
    end
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge clock_in);
    chk("run timeout", 16'h0001, 16'h0000);
    give_verdict();
  end

  // main sequence
  initial begin
    sys_rst_in = 1'b1;
    cause = 3'b000;
    secured = 1'b0;
    bo_en = 1'b1;
    repeat (16) @(negedge clock_in);
    sys_rst_in = 1'b0;
    repeat (3) @(negedge clock_in);
    status(8'h00_00);
    u_cpu.rd(8'h00_A0, rv);
    chk("unmapped", {8'h00, rv}, 16'h0000);
    $display("test reset done");
    // two bytes crossing the nibble wrap
    u_cpu.load(8'h00_12, 8'h00_AE, 8'h00_A1, 2);
    u_cpu.rd(fpepc_pkg::ADDR_ADDR_LOW, rv);
    chk("addr low", {8'h00, rv}, 16'h00A0);
    start();
    chk("hold", {15'h0, hold}, 16'h0001);
    wait_fall(CYC + 40);
    chk("cycle length", 16'(n >= CYC && n <= CYC + 3), 16'h0001);
    chk("erase count", 16'(n_erase), 16'h0001);
    chk("page", {4'h0, seen_page}, 16'h012A);
    chk("write count", 16'(n_wr), 16'h0002);
    chk("byte e", {8'h00, seen_data[14]}, 16'h00A1);
    chk("byte f", {8'h00, seen_data[15]}, 16'h00A2);
    status(8'h00_00);
    $display("test program done");
    // load clears, unknown command keeps buffer
    u_cpu.load(8'h00_12, 8'h00_03, 8'h00_55, 3);
    u_cpu.wr(fpepc_pkg::ADDR_COMMAND_STATUS, fpepc_pkg::CMD_LOAD);
    u_cpu.wr(fpepc_pkg::ADDR_DATA, 8'h00_77);
    u_cpu.wr(fpepc_pkg::ADDR_COMMAND_STATUS, 8'h00_5A);
    @(negedge clock_in);
    chk("hold other", {15'h0, hold}, 16'h0000);
    start();
    wait_fall(CYC + 40);
    chk("flags", seen_flag, 16'h0040);
    chk("byte 6", {8'h00, seen_data[6]}, 16'h0077);
    $display("test load done");
    // aborts by interrupt, voltage fault, brown-out
    for (int k = 0; k < 3; k++) begin
      u_cpu.load(8'h00_12, 8'h00_00, 8'h00_10, 1);
      start();
      cause = 3'(1 << k);
      wait_fall(12);
      cause = 3'b000;
      status(abort_exp[k]);
      repeat (CYC + 16) @(negedge clock_in);
    end
    u_cpu.wr(fpepc_pkg::ADDR_COMMAND_STATUS, fpepc_pkg::CMD_LOAD);
    status(8'h00_00);
    $display("test abort done");
    // refused starts: secured page, detector off
    for (int k = 0; k < 2; k++) begin
      secured = (k == 0);
      bo_en = (k == 0);
      u_cpu.load(8'h00_12, 8'h00_00, 8'h00_10, 1);
      start();
      chk("hold refused", {15'h0, hold}, 16'h0000);
      chk("erase refused", 16'(n_erase), 16'h0000);
      status(k == 0 ? 8'h00_02 : 8'h00_08);
    end
    $display("test refuse done");
    give_verdict();
  end
endmodule
